// File: logic/tdefsm_pkg.sv
package tdefsm_pkg;
	// Blanking interval after a command falling edge
	localparam int BLANK_NS = 200;
	localparam int CLK_PERIOD_NS = 100;
	localparam int BLANK_CYCLES = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_STAGES = 2;
	// Power-up phases
	typedef enum logic [1:0] {
		PWR_RAMP,
		PWR_BUILD,
		PWR_READY
	} power_phase_e;
	// Emulation states: blank (1), watch (2), conduct (3)
	typedef enum logic [1:0] {
		EMU_BLANK,
		EMU_WATCH,
		EMU_CONDUCT
	} emu_state_e;
	// Comparator and flag inputs as one bundle
	typedef struct packed {
		logic drain_negative;
		logic drain_forward_current;
		logic switch_trip;
		logic driver_trip;
		logic supply_above_rise;
		logic supply_below_fall;
		logic five_volt_regulator_good;
		logic negative_rail_good;
	} sense_s;
	localparam int SENSE_W = $bits(sense_s);
endpackage

// File: logic/thermal_diode_emulation_fsm.sv
// What this block does
// - Command falling edge forces state 1 during emulation, except in the switch trip entry cycle
// - State 1 holds off, then goes to 2
// - Blanking is fixed time, no drain wait
// - State 2 off; negative drain goes to 3
// - Entering switch trip starts in state 2
// - State 3 on; forward current goes to 2
// - Without command edges only 2 and 3 alternate
// - No count or block of repeated edges
// - Alarm low during switch thermal shutdown
// - Alarm low from supply ramp start
// - Lockout halts rail build until rise again
// - Both rails good release alarm, follow command
// - Driver trip disables emulation, switch, rails
// - Driver trip clear resumes emulation or normal
module thermal_diode_emulation_fsm #(
	parameter int BLANK_CYCLES = tdefsm_pkg::BLANK_CYCLES
) (
	// Clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic clk_en_i,
	// Command and sense inputs
	input wire logic switch_cmd_i,
	input wire tdefsm_pkg::sense_s sense_i,
	// Outputs
	output logic gate_en_o,
	output logic alarm_n_o,
	output logic rails_en_o,
	output logic emulating_o
);
	localparam int CW = (BLANK_CYCLES > 1) ? $clog2(BLANK_CYCLES + 1) : 1;

	// Refuse a blanking length that the counter cannot serve
	if (BLANK_CYCLES < 1) begin : blank_check
		$error("BLANK_CYCLES must be at least 1");
	end

	tdefsm_pkg::sense_s sync1_r, sense_r;
	logic cmd1_r, cmd_r, cmd_d_r;
	logic trip_d_r;
	tdefsm_pkg::power_phase_e phase_r;
	tdefsm_pkg::emu_state_e emu_r;
	logic [CW-1:0] blank_cnt_r;
	logic cmd_fall, emu_active, trip_rise, fault;

	// Two-flop synchronisers; the first stage feeds only the second
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			sync1_r <= '0;
			sense_r <= '0;
			cmd1_r <= 1'b0;
			cmd_r <= 1'b0;
		end else if (clk_en_i) begin
			sync1_r <= sense_i;
			sense_r <= sync1_r;
			cmd1_r <= switch_cmd_i;
			cmd_r <= cmd1_r;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			cmd_d_r <= 1'b0;
			trip_d_r <= 1'b0;
		end else if (clk_en_i) begin
			cmd_d_r <= cmd_r;
			trip_d_r <= emu_active;
		end
	end

	assign cmd_fall = cmd_d_r & ~cmd_r;
	// Emulation only with switch trip and no driver trip
	assign emu_active = (phase_r == tdefsm_pkg::PWR_READY) && sense_r.switch_trip
		&& !sense_r.driver_trip;
	assign trip_rise = emu_active & ~trip_d_r;
	assign fault = sense_r.switch_trip | sense_r.driver_trip;

	// Power-up sequencing
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			phase_r <= tdefsm_pkg::PWR_RAMP;
		end else if (clk_en_i) begin
			unique case (phase_r)
				tdefsm_pkg::PWR_RAMP: begin
					if (sense_r.supply_above_rise)
						phase_r <= tdefsm_pkg::PWR_BUILD;
				end
				tdefsm_pkg::PWR_BUILD: begin
					if (sense_r.supply_below_fall)
						phase_r <= tdefsm_pkg::PWR_RAMP;
					else if (sense_r.five_volt_regulator_good && sense_r.negative_rail_good)
						phase_r <= tdefsm_pkg::PWR_READY;
				end
				tdefsm_pkg::PWR_READY: begin
					if (sense_r.supply_below_fall)
						phase_r <= tdefsm_pkg::PWR_RAMP;
				end
				default: phase_r <= tdefsm_pkg::PWR_RAMP;
			endcase
		end
	end

	// Emulation state machine; every falling edge in emulation past the trip entry cycle handled alike, no history kept
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			emu_r <= tdefsm_pkg::EMU_WATCH;
		end else if (clk_en_i) begin
			if (!emu_active || trip_rise) begin
				emu_r <= tdefsm_pkg::EMU_WATCH;
			end else if (cmd_fall) begin
				emu_r <= tdefsm_pkg::EMU_BLANK;
			end else begin
				unique case (emu_r)
					tdefsm_pkg::EMU_BLANK: begin
						if (blank_cnt_r == CW'(BLANK_CYCLES - 1))
							emu_r <= tdefsm_pkg::EMU_WATCH;
					end
					tdefsm_pkg::EMU_WATCH: begin
						if (sense_r.drain_negative)
							emu_r <= tdefsm_pkg::EMU_CONDUCT;
					end
					tdefsm_pkg::EMU_CONDUCT: begin
						if (sense_r.drain_forward_current)
							emu_r <= tdefsm_pkg::EMU_WATCH;
					end
					default: emu_r <= tdefsm_pkg::EMU_WATCH;
				endcase
			end
		end
	end

	// Fixed blanking counter; it never waits on drain voltage
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			blank_cnt_r <= '0;
		end else if (clk_en_i) begin
			if (cmd_fall || emu_r != tdefsm_pkg::EMU_BLANK)
				blank_cnt_r <= '0;
			else if (blank_cnt_r != CW'(BLANK_CYCLES - 1))
				blank_cnt_r <= blank_cnt_r + 1'b1;
		end
	end

	// Registered outputs
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			gate_en_o <= 1'b0;
			alarm_n_o <= 1'b0;
			rails_en_o <= 1'b0;
			emulating_o <= 1'b0;
		end else if (clk_en_i) begin
			alarm_n_o <= (phase_r == tdefsm_pkg::PWR_READY) && !fault;
			rails_en_o <= (phase_r != tdefsm_pkg::PWR_RAMP) && !sense_r.driver_trip;
			emulating_o <= emu_active;
			if (phase_r != tdefsm_pkg::PWR_READY || sense_r.driver_trip)
				gate_en_o <= 1'b0;
			else if (sense_r.switch_trip)
				gate_en_o <= emu_active && !trip_rise && !cmd_fall
					&& emu_r == tdefsm_pkg::EMU_CONDUCT;
			else
				gate_en_o <= cmd_r;
		end
	end

	// Assertions
	sequence fall_seen_s;
		emu_active && cmd_fall;
	endsequence

	fall_to_blank_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		fall_seen_s ##0 (clk_en_i && !trip_rise) |=> emu_r == tdefsm_pkg::EMU_BLANK)
		else $error("falling edge did not enter blanking");

	blank_gate_off_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		emu_r == tdefsm_pkg::EMU_BLANK && emu_active && clk_en_i |=> !gate_en_o)
		else $error("gate on during blanking");

	blank_fixed_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		emu_r == tdefsm_pkg::EMU_BLANK && emu_active && !cmd_fall && clk_en_i
		&& blank_cnt_r == CW'(BLANK_CYCLES - 1) |=> emu_r == tdefsm_pkg::EMU_WATCH)
		else $error("blanking did not end on time");

	watch_to_conduct_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		emu_r == tdefsm_pkg::EMU_WATCH && emu_active && !trip_rise && !cmd_fall
		&& sense_r.drain_negative && clk_en_i |=> emu_r == tdefsm_pkg::EMU_CONDUCT)
		else $error("negative drain did not start conduction");

	trip_entry_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		trip_rise && clk_en_i |=> emu_r == tdefsm_pkg::EMU_WATCH)
		else $error("emulation did not start in watch state");

	conduct_gate_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		emu_r == tdefsm_pkg::EMU_CONDUCT && emu_active && !cmd_fall && clk_en_i
		|=> gate_en_o)
		else $error("gate off in conduct state");

	alarm_trip_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		sense_r.switch_trip && clk_en_i |=> !alarm_n_o)
		else $error("alarm released during switch trip");

	lockout_halt_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		phase_r == tdefsm_pkg::PWR_BUILD && sense_r.supply_below_fall && clk_en_i
		|=> phase_r == tdefsm_pkg::PWR_RAMP ##1 !rails_en_o || !clk_en_i)
		else $error("rail build not halted by lockout");

	driver_trip_off_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		sense_r.driver_trip && clk_en_i |=> !gate_en_o && !rails_en_o && !alarm_n_o)
		else $error("driver trip did not shut off");

	sequence emu_run_s;
		emu_active && clk_en_i;
	endsequence

	sequence steady_s;
		emu_active && clk_en_i && !cmd_fall && !trip_rise;
	endsequence

	fall_gate_off_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		fall_seen_s ##0 clk_en_i |=> !gate_en_o)
		else $error("gate on after falling edge");

	blank_hold_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		steady_s ##0 (emu_r == tdefsm_pkg::EMU_BLANK && blank_cnt_r != CW'(BLANK_CYCLES - 1))
		|=> emu_r == tdefsm_pkg::EMU_BLANK)
		else $error("blanking ended early");

	blank_count_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		steady_s ##0 (emu_r == tdefsm_pkg::EMU_BLANK && blank_cnt_r != CW'(BLANK_CYCLES - 1))
		|=> blank_cnt_r == $past(blank_cnt_r) + 1'b1)
		else $error("blanking counter stalled");

	watch_gate_off_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		emu_run_s ##0 emu_r == tdefsm_pkg::EMU_WATCH |=> !gate_en_o)
		else $error("gate on in watch state");

	watch_hold_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		steady_s ##0 (emu_r == tdefsm_pkg::EMU_WATCH && !sense_r.drain_negative)
		|=> emu_r == tdefsm_pkg::EMU_WATCH)
		else $error("watch state left without negative drain");

	trip_gate_off_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		trip_rise && clk_en_i |=> !gate_en_o)
		else $error("gate on at emulation entry");

	conduct_exit_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		steady_s ##0 (emu_r == tdefsm_pkg::EMU_CONDUCT && sense_r.drain_forward_current)
		|=> emu_r == tdefsm_pkg::EMU_WATCH)
		else $error("forward current did not end conduction");

	conduct_hold_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		steady_s ##0 (emu_r == tdefsm_pkg::EMU_CONDUCT && !sense_r.drain_forward_current)
		|=> emu_r == tdefsm_pkg::EMU_CONDUCT)
		else $error("conduction ended without forward current");

	no_idle_blank_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		emu_run_s ##0 (!cmd_fall && emu_r != tdefsm_pkg::EMU_BLANK) |=> emu_r != tdefsm_pkg::EMU_BLANK)
		else $error("blanking entered without falling edge");

	every_fall_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		fall_seen_s ##0 clk_en_i |=> blank_cnt_r == '0)
		else $error("falling edge did not restart blanking");

	alarm_startup_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		phase_r != tdefsm_pkg::PWR_READY && clk_en_i |=> !alarm_n_o)
		else $error("alarm released before rails ready");

	ramp_hold_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		phase_r == tdefsm_pkg::PWR_RAMP && !sense_r.supply_above_rise && clk_en_i
		|=> phase_r == tdefsm_pkg::PWR_RAMP)
		else $error("rail build resumed below rising threshold");

	build_gate_off_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		phase_r != tdefsm_pkg::PWR_READY && clk_en_i |=> !gate_en_o)
		else $error("gate on before rails ready");

	ready_entry_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		phase_r == tdefsm_pkg::PWR_BUILD && !sense_r.supply_below_fall && clk_en_i
		&& sense_r.five_volt_regulator_good && sense_r.negative_rail_good |=> phase_r == tdefsm_pkg::PWR_READY)
		else $error("rails good did not reach ready");

	follow_cmd_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		phase_r == tdefsm_pkg::PWR_READY && !fault && clk_en_i
		|=> alarm_n_o && gate_en_o == $past(cmd_r))
		else $error("normal operation did not follow command");

	driver_emu_off_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		sense_r.driver_trip && clk_en_i |=> !emulating_o)
		else $error("emulation active during driver trip");

	resume_emu_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		phase_r == tdefsm_pkg::PWR_READY && sense_r.switch_trip && !sense_r.driver_trip
		&& clk_en_i |=> emulating_o && !alarm_n_o)
		else $error("emulation did not resume");

	idle_watch_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		!emu_active && clk_en_i |=> emu_r == tdefsm_pkg::EMU_WATCH)
		else $error("emulation state not parked in watch");

	freeze_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		!clk_en_i |=> $stable(emu_r) && $stable(phase_r) && $stable(gate_en_o)
		&& $stable(alarm_n_o))
		else $error("state moved with clock enable low");

	sync_path_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		clk_en_i |=> sense_r == $past(sync1_r))
		else $error("sense synchroniser skipped a stage");
endmodule

// File: testbench/cmd_ctrl.sv
module cmd_ctrl (
	// Clock
	input wire logic ref_clk_i,
	// Command to the switch
	output logic switch_cmd_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial switch_cmd_o = 1'b0;
	// Toggle this device first so that it passes state 1
	task automatic toggle(input int hi);
		@(posedge ref_clk_i);
		#1 switch_cmd_o = 1'b1;
		repeat (hi) @(posedge ref_clk_i);
		#1 switch_cmd_o = 1'b0;
	endtask
endmodule

// File: testbench/thermal_diode_emulation_fsm_tb_top.sv
module thermal_diode_emulation_fsm_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic en = 1'b1;
	logic cmd, gate, alarm_n, rails, emu;
	tdefsm_pkg::sense_s s = '0;
	int miscompares = 0;
	int total_checks = 0;
	always #50 clk = ~clk;
	cmd_ctrl ctl (.ref_clk_i(clk), .switch_cmd_o(cmd));
	// Longer blanking than default, so the hold-off is visible
	thermal_diode_emulation_fsm #(.BLANK_CYCLES(4)) uut (
		.ref_clk_i(clk),
		.srst_i(srst),
		.clk_en_i(en),
		.switch_cmd_i(cmd),
		.sense_i(s),
		.gate_en_o(gate),
		.alarm_n_o(alarm_n),
		.rails_en_o(rails),
		.emulating_o(emu)
	);
	task automatic chk(string nm, logic e, logic g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %b got %b", nm, e, g);
		end
	endtask
	// Bounded wait, then compare
	task automatic wt(string nm, ref logic g, input logic e);
		for (int i = 0; i < 20 && g !== e; i++) begin
			@(posedge clk);
			#1;
		end
		chk(nm, e, g);
	endtask
	task automatic power_up();
		chk("alarm", 1'b0, alarm_n);
		s.supply_above_rise = 1'b1;
		wt("rails", rails, 1'b1);
		s.supply_above_rise = 1'b0;
		s.supply_below_fall = 1'b1;
		wt("rails", rails, 1'b0);
		s.supply_below_fall = 1'b0;
		s.five_volt_regulator_good = 1'b1;
		s.negative_rail_good = 1'b1;
		repeat (8) @(posedge clk);
		#1 chk("alarm", 1'b0, alarm_n);
		s.supply_above_rise = 1'b1;
		wt("alarm", alarm_n, 1'b1);
		fork
			ctl.toggle(6);
			wt("gate", gate, 1'b1);
		join
		wt("gate", gate, 1'b0);
		$display("done power_up");
	endtask
	task automatic emulate();
		s.switch_trip = 1'b1;
		wt("alarm", alarm_n, 1'b0);
		wt("emu", emu, 1'b1);
		chk("gate", 1'b0, gate);
		repeat (2) begin
			s.drain_negative = 1'b1;
			wt("gate", gate, 1'b1);
			s.drain_negative = 1'b0;
			s.drain_forward_current = 1'b1;
			wt("gate", gate, 1'b0);
			s.drain_forward_current = 1'b0;
		end
		$display("done emulate");
	endtask
	// Clock enable low must hold the machine in watch
	task automatic freeze();
		en = 1'b0;
		s.drain_negative = 1'b1;
		repeat (6) @(posedge clk);
		#1 chk("gate", 1'b0, gate);
		chk("emu", 1'b1, emu);
		en = 1'b1;
		wt("gate", gate, 1'b1);
		$display("done freeze");
	endtask
	// Drain stays negative: no positive drain voltage ever appears
	task automatic blank();
		s.drain_negative = 1'b1;
		wt("gate", gate, 1'b1);
		repeat (2) begin
			ctl.toggle(2);
			wt("gate", gate, 1'b0);
			repeat (2) @(posedge clk);
			#1 chk("gate", 1'b0, gate);
			wt("gate", gate, 1'b1);
		end
		$display("done blank");
	endtask
	task automatic drv_trip();
		s.driver_trip = 1'b1;
		wt("emu", emu, 1'b0);
		wt("gate", gate, 1'b0);
		wt("rails", rails, 1'b0);
		s.driver_trip = 1'b0;
		wt("emu", emu, 1'b1);
		wt("gate", gate, 1'b1);
		s.switch_trip = 1'b0;
		s.drain_negative = 1'b0;
		wt("alarm", alarm_n, 1'b1);
		$display("done drv_trip");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		#1 srst = 1'b0;
		power_up();
		emulate();
		freeze();
		blank();
		drv_trip();
		tally_and_finish();
	end
	initial begin
		#200000;
		miscompares++;
		tally_and_finish();
	end
endmodule
